//--- logic/stw_pkg.sv
// shared constants and types for the two-wire memory link
package stw_pkg;
   localparam int CLK_FREQ_HZ        = 50_000_000;
   localparam int CLK_PERIOD_NS      = 20;
   // longest programming time, in ms, and its cycle count (rounded down)
   localparam int PROG_TIME_MS       = 5;
   localparam int PROG_CYCLES        = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);
   // serial clock made by the master end
   localparam int SCL_PERIOD_NS      = 10000;
   localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int WORD_BITS          = 8;
   localparam int ADDR_BITS          = 16;
   localparam int PAGE_ADDR_BITS     = 7;
   localparam int PAGE_BYTES         = 128;
   localparam int PAGE_COUNT         = 512;
   localparam int RECOVER_PULSES     = 9;
   // memory type code; the value is arbitrary
   localparam logic [3:0] TYPE_CODE_DEFAULT = 4'h5;
   // bit counter values
   localparam logic [2:0] BIT_FIRST  = 3'h0;
   localparam logic [2:0] BIT_LAST   = 3'h7;
   localparam logic [3:0] BIT_ACK    = 4'h8;
   // position of a received byte within a command
   localparam logic [1:0] BYTE_DEV     = 2'h0;
   localparam logic [1:0] BYTE_ADDR_HI = 2'h1;
   localparam logic [1:0] BYTE_ADDR_LO = 2'h2;
   localparam logic [1:0] BYTE_DATA    = 2'h3;
   // pin sample vector: {wp, strap2, strap1, strap0, scl, sda}
   localparam logic [5:0] PIN_IDLE   = 6'h03;
   localparam int PIN_SDA = 0;
   localparam int PIN_SCL = 1;
   localparam int PIN_WP  = 5;
   localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
   typedef enum logic [1:0] {stw_cmd_write, stw_cmd_poll, stw_cmd_recover} stw_cmd_type;
endpackage

//--- logic/stw_link_if.sv
// two-wire link between master end and memory end, with open-drain data
`timescale 1ns/100ps
interface stw_link_if;
   logic scl;
   logic sda;
   logic mst_sda_out;
   logic mst_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;

   // wired-and with pull-up: any enabled low driver wins
   assign sda = !((mst_sda_oe && !mst_sda_out) || (dev_sda_oe && !dev_sda_out));

   modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe);
   modport master (output scl, input sda, output mst_sda_out, output mst_sda_oe);
endinterface

//--- logic/stw_device.sv
// memory end of the two-wire link: address match, page buffer, programming
`timescale 1ns/100ps
module stw_device #(
   parameter int         PROG_CYCLES = stw_pkg::PROG_CYCLES,
   parameter logic [3:0] TYPE_CODE   = stw_pkg::TYPE_CODE_DEFAULT
) (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   stw_link_if.device                         link,
   input  wire logic                          chip_select_strap_2,
   input  wire logic                          chip_select_strap_1,
   input  wire logic                          chip_select_strap_0,
   input  wire logic                          write_protect,
   output logic                               mem_wr_en,
   output logic [stw_pkg::ADDR_BITS-1:0]      mem_wr_addr,
   output logic [stw_pkg::WORD_BITS-1:0]      mem_wr_data,
   output logic [stw_pkg::ADDR_BITS-1:0]      mem_rd_addr,
   input  wire logic [stw_pkg::WORD_BITS-1:0] mem_rd_data,
   output logic                               standby,
   output logic                               busy
);
   import stw_pkg::*;

   typedef enum {st_idle, st_rx, st_ack, st_tx, st_mack} stw_dev_state_type;

   localparam int PROG_W = $clog2(PROG_CYCLES + 1);

   logic [5:0]                pin_s1_reg;
   logic [5:0]                pin_s2_reg;
   logic                      scl_d_reg;
   logic                      sda_d_reg;
   stw_dev_state_type         state_reg;
   logic [2:0]                bit_cnt_reg;
   logic [WORD_BITS-1:0]      shift_reg;
   logic [WORD_BITS-1:0]      tx_reg;
   logic [1:0]                phase_reg;
   logic                      rw_reg;
   logic                      got_byte_reg;
   logic                      mack_reg;
   logic                      wr_pend_reg;
   logic                      sda_oe_reg;
   logic [ADDR_BITS-1:0]      addr_reg;
   logic                      busy_reg;
   logic [PROG_W-1:0]         prog_cnt_reg;
   logic [PAGE_ADDR_BITS-1:0] prog_idx_reg;
   logic [WORD_BITS-1:0]      page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0]     valid_reg;

   logic scl_now;
   logic sda_now;
   logic wp_now;
   logic [2:0] straps_now;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic dev_match;
   logic byte_end;
   logic capture;
   logic prog_start;

   // pins come from outside the clock domain: two flops before any use
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1_reg <= PIN_IDLE;
         pin_s2_reg <= PIN_IDLE;
      end else begin
         pin_s1_reg <= {write_protect, chip_select_strap_2, chip_select_strap_1,
                        chip_select_strap_0, link.scl, link.sda};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   assign scl_now    = pin_s2_reg[PIN_SCL];
   assign sda_now    = pin_s2_reg[PIN_SDA];
   assign wp_now     = pin_s2_reg[PIN_WP];
   assign straps_now = pin_s2_reg[PIN_WP-1:PIN_SCL+1];

   // one more stage for edge detection, fed from the second flop only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_now;
         sda_d_reg <= sda_now;
      end
   end

   assign scl_rise   = scl_now && !scl_d_reg;
   assign scl_fall   = !scl_now && scl_d_reg;
   // data moving while clock stays high marks a frame boundary
   assign start_seen = scl_now && scl_d_reg && sda_d_reg && !sda_now;
   assign stop_seen  = scl_now && scl_d_reg && !sda_d_reg && sda_now;

   // address word check; a busy device answers nothing, which enables polling
   assign dev_match  = (shift_reg[7:4] == TYPE_CODE)
                       && (shift_reg[3:1] == straps_now)
                       && !busy_reg;
   assign byte_end   = (state_reg == st_rx) && scl_fall && got_byte_reg;
   assign capture    = byte_end && (phase_reg == BYTE_DATA) && !wp_now;
   assign prog_start = stop_seen && wr_pend_reg && !wp_now && !busy_reg;

   // protocol engine: receive, acknowledge, transmit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg    <= st_idle;
         bit_cnt_reg  <= BIT_FIRST;
         shift_reg    <= '0;
         tx_reg       <= '0;
         phase_reg    <= BYTE_DEV;
         rw_reg       <= 1'b0;
         got_byte_reg <= 1'b0;
         mack_reg     <= 1'b0;
         wr_pend_reg  <= 1'b0;
         sda_oe_reg   <= 1'b0;
         addr_reg     <= '0;
      end else if (start_seen) begin
         // a repeated start abandons any byte in flight
         state_reg    <= st_rx;
         bit_cnt_reg  <= BIT_FIRST;
         phase_reg    <= BYTE_DEV;
         got_byte_reg <= 1'b0;
         sda_oe_reg   <= 1'b0;
      end else if (stop_seen) begin
         state_reg    <= st_idle;
         sda_oe_reg   <= 1'b0;
         wr_pend_reg  <= 1'b0;
      end else begin
         case (state_reg)
            st_idle: begin
               sda_oe_reg <= 1'b0;
            end
            st_rx: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[WORD_BITS-2:0], sda_now};
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == BIT_LAST) begin
                     got_byte_reg <= 1'b1;
                  end
               end else if (byte_end) begin
                  got_byte_reg <= 1'b0;
                  if (phase_reg == BYTE_DEV && !dev_match) begin
                     state_reg <= st_idle;
                  end else begin
                     state_reg  <= st_ack;
                     sda_oe_reg <= 1'b1;
                  end
                  case (phase_reg)
                     BYTE_DEV:     rw_reg <= shift_reg[0];
                     BYTE_ADDR_HI: addr_reg[ADDR_BITS-1:WORD_BITS] <= shift_reg;
                     BYTE_ADDR_LO: addr_reg[WORD_BITS-1:0] <= shift_reg;
                     default: begin
                        // page row stays, column wraps inside the page
                        addr_reg[PAGE_ADDR_BITS-1:0] <=
                           addr_reg[PAGE_ADDR_BITS-1:0] + 7'h1;
                        wr_pend_reg <= 1'b1;
                     end
                  endcase
                  if (phase_reg != BYTE_DATA) begin
                     phase_reg <= phase_reg + 2'h1;
                  end
               end
            end
            st_ack: begin
               if (scl_fall) begin
                  bit_cnt_reg <= BIT_FIRST;
                  if (rw_reg) begin
                     state_reg  <= st_tx;
                     tx_reg     <= mem_rd_data;
                     sda_oe_reg <= !mem_rd_data[WORD_BITS-1];
                     addr_reg   <= addr_reg + 16'h1;
                  end else begin
                     state_reg  <= st_rx;
                     sda_oe_reg <= 1'b0;
                  end
               end
            end
            st_tx: begin
               if (scl_fall) begin
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == BIT_LAST) begin
                     state_reg  <= st_mack;
                     sda_oe_reg <= 1'b0;
                  end else begin
                     tx_reg     <= {tx_reg[WORD_BITS-2:0], 1'b0};
                     sda_oe_reg <= !tx_reg[WORD_BITS-2];
                  end
               end
            end
            st_mack: begin
               if (scl_rise) begin
                  mack_reg <= !sda_now;
               end else if (scl_fall) begin
                  if (mack_reg) begin
                     state_reg  <= st_tx;
                     bit_cnt_reg <= BIT_FIRST;
                     tx_reg     <= mem_rd_data;
                     sda_oe_reg <= !mem_rd_data[WORD_BITS-1];
                     addr_reg   <= addr_reg + 16'h1;
                  end else begin
                     state_reg <= st_idle;
                  end
               end
            end
            default: state_reg <= st_idle;
         endcase
      end
   end

   // self-timed programming window; no stop can restart it early
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_reg     <= 1'b0;
         prog_cnt_reg <= '0;
      end else if (prog_start) begin
         busy_reg     <= 1'b1;
         prog_cnt_reg <= PROG_W'(PROG_CYCLES - 1);
      end else if (busy_reg) begin
         if (prog_cnt_reg == '0) begin
            busy_reg <= 1'b0;
         end else begin
            prog_cnt_reg <= prog_cnt_reg - PROG_W'(1);
         end
      end
   end

   // page buffer: a later byte at the same column replaces the earlier one
   always_ff @(posedge clk) begin
      if (capture) begin
         page_buf[addr_reg[PAGE_ADDR_BITS-1:0]] <= shift_reg;
      end
   end

   // column valid bits; a blocked or abandoned write discards the page
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         valid_reg <= '0;
      end else if (capture) begin
         valid_reg[addr_reg[PAGE_ADDR_BITS-1:0]] <= 1'b1;
      end else if (stop_seen && !prog_start && !busy_reg) begin
         valid_reg <= '0;
      end else if (busy_reg) begin
         valid_reg[prog_idx_reg] <= 1'b0;
      end
   end

   // array write-out during programming, one column per clock;
   // needs a programming count of at least one page
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prog_idx_reg <= '0;
         mem_wr_en    <= 1'b0;
         mem_wr_addr  <= '0;
         mem_wr_data  <= '0;
         standby      <= 1'b1;
      end else begin
         prog_idx_reg <= busy_reg ? prog_idx_reg + 7'h1 : '0;
         mem_wr_en    <= busy_reg && valid_reg[prog_idx_reg];
         mem_wr_addr  <= {addr_reg[ADDR_BITS-1:PAGE_ADDR_BITS], prog_idx_reg};
         mem_wr_data  <= page_buf[prog_idx_reg];
         standby      <= (state_reg == st_idle) && !busy_reg;
      end
   end

   assign mem_rd_addr      = addr_reg;
   assign busy             = busy_reg;
   assign link.dev_sda_out = 1'b0;
   assign link.dev_sda_oe  = sda_oe_reg;
endmodule

//--- logic/stw_master.sv
// master end of the two-wire link: writes, address polling, bus recovery
`timescale 1ns/100ps
module stw_master #(
   parameter int         QUARTER   = stw_pkg::SCL_QUARTER_CYCLES,
   parameter logic [3:0] TYPE_CODE = stw_pkg::TYPE_CODE_DEFAULT
) (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   stw_link_if.master                         link,
   input  wire logic                          cmd_valid,
   output logic                               cmd_ready,
   input  wire stw_pkg::stw_cmd_type          cmd_kind,
   input  wire logic [2:0]                    cmd_select,
   input  wire logic                          cmd_read,
   input  wire logic [stw_pkg::ADDR_BITS-1:0] cmd_addr,
   input  wire logic [stw_pkg::WORD_BITS-1:0] cmd_count,
   input  wire logic [stw_pkg::WORD_BITS-1:0] wr_data,
   output logic                               wr_data_take,
   output logic                               done,
   output logic                               nacked
);
   import stw_pkg::*;

   typedef enum {m_idle, m_start, m_bit, m_stop} stw_mst_state_type;

   localparam int QW = $clog2(QUARTER + 1);

   stw_mst_state_type    state_reg;
   logic [QW-1:0]        qcnt_reg;
   logic [1:0]           q_reg;
   logic [3:0]           bit_reg;
   logic [WORD_BITS-1:0] sh_reg;
   logic [1:0]           phase_reg;
   logic [WORD_BITS-1:0] left_reg;
   stw_cmd_type          kind_reg;
   logic [ADDR_BITS-1:0] addr_reg;
   logic                 rec_again_reg;
   logic                 ack_reg;
   logic                 scl_reg;
   logic                 sda_oe_reg;
   logic [1:0]           sda_sync_reg;
   logic                 tick;

   // quarter-period divider makes the serial clock
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         qcnt_reg <= '0;
      end else begin
         qcnt_reg <= (qcnt_reg == QW'(QUARTER - 1)) ? '0 : qcnt_reg + QW'(1);
      end
   end
   assign tick = (qcnt_reg == QW'(QUARTER - 1));

   // returned data line passes two flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_sync_reg <= 2'h3;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], link.sda};
      end
   end

   // quarter 0: data set with clock low, 1: clock high, 2: sample/edge, 3: low (stop leaves it high)
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg     <= m_idle;
         q_reg         <= 2'h0;
         bit_reg       <= 4'h0;
         sh_reg        <= '0;
         phase_reg     <= BYTE_DEV;
         left_reg      <= '0;
         kind_reg      <= stw_cmd_write;
         addr_reg      <= '0;
         rec_again_reg <= 1'b0;
         ack_reg       <= 1'b0;
         scl_reg       <= 1'b1;
         sda_oe_reg    <= 1'b0;
         wr_data_take  <= 1'b0;
         done          <= 1'b0;
         nacked        <= 1'b0;
      end else begin
         wr_data_take <= 1'b0;
         done         <= 1'b0;
         case (state_reg)
            m_idle: begin
               if (cmd_valid) begin
                  state_reg     <= m_start;
                  q_reg         <= 2'h0;
                  kind_reg      <= cmd_kind;
                  addr_reg      <= cmd_addr;
                  left_reg      <= cmd_count;
                  phase_reg     <= BYTE_DEV;
                  rec_again_reg <= 1'b0;
                  nacked        <= 1'b0;
                  sh_reg        <= {TYPE_CODE, cmd_select, cmd_read};
               end
            end
            m_start: if (tick) begin
               q_reg <= q_reg + 2'h1;
               case (q_reg)
                  2'h0: begin scl_reg <= 1'b0; sda_oe_reg <= 1'b0; end
                  2'h1: scl_reg <= 1'b1;
                  2'h2: sda_oe_reg <= 1'b1;
                  default: begin
                     scl_reg <= 1'b0;
                     bit_reg <= 4'h0;
                     if (rec_again_reg) begin
                        state_reg <= m_stop;
                     end else begin
                        state_reg <= m_bit;
                        if (kind_reg == stw_cmd_recover) begin
                           sh_reg <= BYTE_ALL_ONES;
                        end
                     end
                  end
               endcase
            end
            m_bit: if (tick) begin
               q_reg <= q_reg + 2'h1;
               case (q_reg)
                  2'h0: sda_oe_reg <= (bit_reg == BIT_ACK) ? 1'b0 : !sh_reg[WORD_BITS-1];
                  2'h1: scl_reg <= 1'b1;
                  2'h2: ack_reg <= !sda_sync_reg[1];
                  default: begin
                     scl_reg <= 1'b0;
                     sh_reg  <= {sh_reg[WORD_BITS-2:0], 1'b1};
                     bit_reg <= bit_reg + 4'h1;
                     if (bit_reg == BIT_ACK) begin
                        bit_reg <= 4'h0;
                        if (kind_reg == stw_cmd_recover) begin
                           state_reg     <= m_start;
                           rec_again_reg <= 1'b1;
                        end else if (!ack_reg) begin
                           state_reg <= m_stop;
                           nacked    <= 1'b1;
                        end else if (kind_reg == stw_cmd_poll) begin
                           state_reg <= m_stop;
                        end else if (phase_reg == BYTE_DEV) begin
                           sh_reg    <= addr_reg[ADDR_BITS-1:WORD_BITS];
                           phase_reg <= BYTE_ADDR_HI;
                        end else if (phase_reg == BYTE_ADDR_HI) begin
                           sh_reg    <= addr_reg[WORD_BITS-1:0];
                           phase_reg <= BYTE_ADDR_LO;
                        end else if (left_reg == '0) begin
                           state_reg <= m_stop;
                        end else begin
                           sh_reg       <= wr_data;
                           wr_data_take <= 1'b1;
                           left_reg     <= left_reg - 8'h1;
                           phase_reg    <= BYTE_DATA;
                        end
                     end
                  end
               endcase
            end
            m_stop: if (tick) begin
               q_reg <= q_reg + 2'h1;
               case (q_reg)
                  2'h0: sda_oe_reg <= 1'b1;
                  2'h1: scl_reg <= 1'b1;
                  2'h2: sda_oe_reg <= 1'b0;
                  default: begin
                     state_reg <= m_idle;
                     done      <= 1'b1;
                  end
               endcase
            end
            default: state_reg <= m_idle;
         endcase
      end
   end

   assign cmd_ready        = (state_reg == m_idle);
   assign link.scl         = scl_reg;
   assign link.mst_sda_out = 1'b0;
   assign link.mst_sda_oe  = sda_oe_reg;
endmodule

//--- tb/stw_props.sv
// concurrent checks on the two-wire link signals
`timescale 1ns/100ps
module stw_props (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       scl,
   input wire logic       sda,
   input wire logic       mst_sda_out,
   input wire logic       mst_sda_oe,
   input wire logic       dev_sda_out,
   input wire logic       dev_sda_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [7:0] low_cnt;
   // age of the clock-low phase, so device moves can be tied to the fall
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         low_cnt <= 8'h00;
      else if (scl)
         low_cnt <= 8'h00;
      else if (low_cnt != 8'hff)
         low_cnt <= low_cnt + 8'h01;
   end
   dev_low_only_a: assert property (dev_sda_oe |-> !dev_sda_out)
      else $error("device drove data high");
   mst_low_only_a: assert property (mst_sda_oe |-> !mst_sda_out)
      else $error("master drove data high");
   ack_on_wire_a: assert property (dev_sda_oe |-> !sda)
      else $error("acknowledge not seen on data line");
   dev_edge_low_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
      else $error("device moved data with clock high");
   ack_delay_a: assert property ($rose(dev_sda_oe) |-> low_cnt inside {[1:8]})
      else $error("device drive not just after clock fall");
   ack_release_a: assert property ($fell(dev_sda_oe) |-> low_cnt inside {[1:8]})
      else $error("device release not just after clock fall");
   ack_hold_a: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe[*8])
      else $error("acknowledge dropped in clock high");
   scl_high_a: assert property ($rose(scl) |-> scl[*8])
      else $error("clock high phase too short");
   scl_low_a: assert property ($fell(scl) |=> !scl[*7])
      else $error("clock low phase too short");
endmodule

//--- tb/serial_eeprom_two_wire_write_slave_test.sv
// self-checking bench: master end writes to memory end across the link
`timescale 1ns/100ps
module serial_eeprom_two_wire_write_slave_test;
   import stw_pkg::*;
   // long enough that a poll lands inside the programming window
   localparam int PROG = 1000;
   typedef struct {logic [2:0] sel; logic [15:0] addr; int cnt; logic [7:0] base;
                   logic wp; logic nack; int nwr;} stw_row_type;
   logic             clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
   logic             wp = 1'b0, busy_seen = 1'b0, row_bad = 1'b0, model_clear = 1'b0;
   logic             cmd_ready, wr_take, done, nacked, mem_wr_en, standby, busy;
   logic [2:0]       cmd_select = 3'h0, straps = 3'h5;
   logic [15:0]      cmd_addr = 16'h0000, wr_addr, rd_addr;
   logic [7:0]       cmd_count = 8'h00, wr_data = 8'h00, data_base = 8'h00, wd, got [128];
   logic [8:0]       row = 9'h000;
   stw_cmd_type      cmd_kind = stw_cmd_write;
   int               err_count = 0, checks_done = 0, nwr = 0, i;
   stw_link_if       link ();
   stw_row_type      rows [6] = '{
      '{3'h5, 16'h1234, 1, 8'h3c, 1'b0, 1'b0, 1},   // single byte
      '{3'h5, 16'h00fe, 4, 8'h10, 1'b0, 1'b0, 4},   // crosses the page end
      '{3'h3, 16'h0040, 2, 8'h20, 1'b0, 1'b1, 0},   // other straps
      '{3'h5, 16'h0200, 2, 8'h30, 1'b1, 1'b0, 0},   // protected
      '{3'h5, 16'h0300, 0, 8'h00, 1'b0, 1'b0, 0},   // address only
      '{3'h5, 16'hff85, 130, 8'h40, 1'b0, 1'b0, 128}};
   stw_master #(.QUARTER(8)) stw_master_i (.clk(clk), .reset_n(reset_n), .link(link.master),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
      .cmd_select(cmd_select), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
      .cmd_count(cmd_count), .wr_data(wr_data), .wr_data_take(wr_take), .done(done),
      .nacked(nacked));
   stw_device #(.PROG_CYCLES(PROG)) stw_device_i (.clk(clk), .reset_n(reset_n),
      .link(link.device), .chip_select_strap_2(straps[2]), .chip_select_strap_1(straps[1]),
      .chip_select_strap_0(straps[0]), .write_protect(wp), .mem_wr_en(mem_wr_en),
      .mem_wr_addr(wr_addr), .mem_wr_data(wd), .mem_rd_addr(rd_addr),
      .mem_rd_data(8'ha5), .standby(standby), .busy(busy));
   stw_props stw_props_i (.clk(clk), .reset_n(reset_n), .scl(link.scl), .sda(link.sda),
      .mst_sda_out(link.mst_sda_out), .mst_sda_oe(link.mst_sda_oe),
      .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe));
   // array model: keeps bytes by column, flags a write outside the page
   // sole driver of its flags; the command task only asks for a clear
   always @(posedge clk) begin
      if (model_clear) begin
         busy_seen <= 1'b0;
         row_bad <= 1'b0;
         nwr <= 0;
         wr_data <= data_base;
      end else begin
         if (busy)
            busy_seen <= 1'b1;
         if (mem_wr_en) begin
            got[wr_addr[6:0]] <= wd;
            nwr <= nwr + 1;
            if (wr_addr[15:7] !== row)
               row_bad <= 1'b1;
         end
         if (wr_take)
            wr_data <= wr_data + 8'h01;
      end
   end
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic complete_run();
      if (err_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one command, valid for a single clock, then bounded wait for done
   task automatic run(input stw_cmd_type k, input logic [2:0] s, input logic [15:0] a,
                      input int n, input logic [7:0] b);
      int t;
      @(posedge clk);
      cmd_kind <= k;
      cmd_select <= s;
      cmd_addr <= a;
      cmd_count <= n[7:0];
      data_base <= b;
      row <= a[15:7];
      model_clear <= 1'b1;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      model_clear <= 1'b0;
      for (t = 0; t < 40000 && done !== 1'b1; t++) @(posedge clk);
      if (done !== 1'b1) begin
         err_count++;
         complete_run();
      end
   endtask
   // programming window is a count we set, so a fixed wait covers it
   task automatic settle();
      repeat (PROG + 40) @(posedge clk);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      check("standby", 1'b1, standby);
      foreach (rows[r]) begin
         wp <= rows[r].wp;
         run(stw_cmd_write, rows[r].sel, rows[r].addr, rows[r].cnt, rows[r].base);
         check("nacked", rows[r].nack, nacked);
         settle();
         check("writes", rows[r].nwr, nwr);
         check("busy_seen", rows[r].nwr > 0, busy_seen);
         check("row_bad", 1'b0, row_bad);
         check("standby", 1'b1, standby);
         for (i = rows[r].cnt - rows[r].nwr; i < rows[r].cnt; i++)
            check("data", rows[r].base + i[7:0], got[rows[r].addr[6:0] + i[6:0]]);
      end
      // poll inside the programming window, then after it
      run(stw_cmd_write, 3'h5, 16'h0500, 1, 8'h77);
      run(stw_cmd_poll, 3'h5, 16'h0000, 0, 8'h00);
      check("poll_busy", 1'b1, nacked);
      settle();
      run(stw_cmd_poll, 3'h5, 16'h0000, 0, 8'h00);
      check("poll_idle", 1'b0, nacked);
      // read-direction poll on other straps; 3'h5 alone hides a swapped order
      straps <= 3'h6;
      cmd_read <= 1'b1;
      run(stw_cmd_poll, 3'h6, 16'h0000, 0, 8'h00);
      check("poll_read", 1'b0, nacked);
      straps <= 3'h5;
      cmd_read <= 1'b0;
      // reset during programming must drop back to standby
      run(stw_cmd_write, 3'h5, 16'h0600, 1, 8'h66);
      check("busy_pre", 1'b1, busy);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      check("busy_rst", 1'b0, busy);
      check("standby_rst", 1'b1, standby);
      check("ready_rst", 1'b1, cmd_ready);
      reset_n <= 1'b1;
      run(stw_cmd_recover, 3'h0, 16'h0000, 0, 8'h00);
      run(stw_cmd_write, 3'h5, 16'h0701, 1, 8'h99);
      settle();
      check("recover_wr", 1, nwr);
      check("recover_data", 8'h99, got[1]);
      check("rd_addr", 16'h0702, rd_addr);
      complete_run();
   end
endmodule
